// ### core/input_sync.sv
`timescale 1ns/1ps
module input_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // lanes
  sync_if.sync_side s
);

  typedef struct packed {
    logic [wdgate_pkg::SYNC_W-1:0] meta;
    logic [wdgate_pkg::SYNC_W-1:0] stab;
    logic [wdgate_pkg::SYNC_W-1:0] prev;
  } sync_state_type;

  sync_state_type r;
  sync_state_type r_nxt;

  // meta is read only by stab; edges come from the settled stages
  always_comb begin
    r_nxt      = r;
    r_nxt.meta = s.raw;
    r_nxt.stab = r.meta;
    r_nxt.prev = r.stab;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign s.sync = r.stab;
  assign s.rise = r.stab & ~r.prev;

  AST_RISE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    s.rise[wdgate_pkg::IN_TRIG] |=> !s.rise[wdgate_pkg::IN_TRIG])
    else $error("trigger edge lasted more than one cycle");

endmodule : input_sync

// ### core/sync_if.sv
`timescale 1ns/1ps
interface sync_if;
  logic [wdgate_pkg::SYNC_W-1:0] raw;
  logic [wdgate_pkg::SYNC_W-1:0] sync;
  logic [wdgate_pkg::SYNC_W-1:0] rise;

  modport sync_side (input raw, output sync, output rise);
  modport user_side (output raw, input sync, input rise);
endinterface : sync_if

// ### core/wd_activation_gate.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module wd_activation_gate (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins and detector levels
  input  wire logic        watchdog_gate,
  input  wire logic        current_threshold_sense,
  input  wire logic        trigger_input,
  input  wire logic        release_threshold_ok,
  input  wire logic        detect_threshold_low,
  input  wire logic        undervoltage_reset_output,
  // outputs
  output logic             fault_output,
  output logic             combined_status_output,
  output logic             monitor_active,
  output logic             irq
);

  typedef struct packed {
    wdgate_pkg::wd_state_type st;
    logic [15:0]              cnt;
    logic                     fault;
    logic                     active;
    logic                     vout_ok;
    logic                     comb;
    logic                     trig_acc;
    logic [1:0]               ctrl;
    logic [wdgate_pkg::EV_W-1:0] irq_st;
    logic [wdgate_pkg::EV_W-1:0] irq_en;
    logic                     irq;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } core_type;

  core_type r;
  core_type r_nxt;
  sync_if   sif ();

  logic gate_s;
  logic det_low_s;
  logic sense_stat;
  logic act_nxt;
  logic trig_ok;
  logic uv_trip;
  logic acc_phase;
  logic [wdgate_pkg::EV_W-1:0] ev;

  // pull-downs of the gate and trigger pins live in the pad; a floating pin arrives low
  assign sif.raw = {undervoltage_reset_output, detect_threshold_low, release_threshold_ok,
                    trigger_input, current_threshold_sense, watchdog_gate};

  input_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (sif)
  );

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == wdgate_pkg::ADDR_CTRL) || (a == wdgate_pkg::ADDR_STATUS) ||
             (a == wdgate_pkg::ADDR_IRQ_STAT) || (a == wdgate_pkg::ADDR_IRQ_CLR) ||
             (a == wdgate_pkg::ADDR_IRQ_EN);
  endfunction : mapped

  function automatic logic [31:0] rd_word(input logic [11:0] a, input core_type q,
                                          input logic g, input logic sn);
    rd_word = 32'h0000_0000;
    unique case (a)
      wdgate_pkg::ADDR_CTRL:     rd_word[1:0] = q.ctrl;
      wdgate_pkg::ADDR_STATUS: begin
        rd_word[wdgate_pkg::ST_ACTIVE]  = q.active;
        rd_word[wdgate_pkg::ST_FAULT]   = q.fault;
        rd_word[wdgate_pkg::ST_GATE]    = g;
        rd_word[wdgate_pkg::ST_SENSE]   = sn;
        rd_word[wdgate_pkg::ST_VOUT_OK] = q.vout_ok;
        rd_word[wdgate_pkg::ST_STATE +: 3] = q.st;
      end
      wdgate_pkg::ADDR_IRQ_STAT: rd_word[wdgate_pkg::EV_W-1:0] = q.irq_st;
      wdgate_pkg::ADDR_IRQ_EN:   rd_word[wdgate_pkg::EV_W-1:0] = q.irq_en;
      default:                   rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  always_comb begin
    r_nxt     = r;
    gate_s    = sif.sync[wdgate_pkg::IN_GATE];
    det_low_s = sif.sync[wdgate_pkg::IN_DET_LOW];
    ev        = '0;

    // output voltage window with hysteresis between the two thresholds
    if (det_low_s) begin
      r_nxt.vout_ok = 1'b0;
    end else if (sif.sync[wdgate_pkg::IN_REL_OK]) begin
      r_nxt.vout_ok = 1'b1;
    end
    uv_trip = r.vout_ok && !r_nxt.vout_ok;

    // a disabled gate also stops the current detection path
    unique case (r.ctrl)
      wdgate_pkg::SENSE_UNUSED: sense_stat = 1'b0;
      wdgate_pkg::SENSE_ALWAYS: sense_stat = gate_s;
      default:                  sense_stat = gate_s && sif.sync[wdgate_pkg::IN_SENSE];
    endcase
    // the comparator hysteresis is analog; the digital side just follows its level
    act_nxt      = gate_s && sense_stat && r_nxt.vout_ok;
    r_nxt.active = act_nxt;
    if (act_nxt != r.active) begin
      ev[wdgate_pkg::EV_ACTCHG] = 1'b1;
    end

    trig_ok = sif.rise[wdgate_pkg::IN_TRIG] && r.active && r.fault &&
              (r.st == wdgate_pkg::WD_OPEN || r.st == wdgate_pkg::WD_CLOSED);
    r_nxt.trig_acc = trig_ok;
    if (trig_ok) begin
      ev[wdgate_pkg::EV_TRIGGER] = 1'b1;
    end

    if (!r_nxt.vout_ok) begin
      // undervoltage overrides everything, including a fault in progress
      r_nxt.st    = wdgate_pkg::WD_IDLE;
      r_nxt.cnt   = 16'h0000;
      r_nxt.fault = 1'b1;
    end else begin
      unique case (r.st)
        wdgate_pkg::WD_IDLE: begin
          r_nxt.cnt = 16'h0000;
          if (act_nxt || uv_trip) begin
            r_nxt.st = act_nxt ? wdgate_pkg::WD_POR : wdgate_pkg::WD_IDLE;
          end
        end
        wdgate_pkg::WD_POR: begin
          r_nxt.cnt = 16'h0000;
          r_nxt.st  = act_nxt ? wdgate_pkg::WD_OPEN : wdgate_pkg::WD_IDLE;
        end
        wdgate_pkg::WD_OPEN: begin
          if (!act_nxt) begin
            r_nxt.st  = wdgate_pkg::WD_IDLE;
            r_nxt.cnt = 16'h0000;
          end else if (trig_ok) begin
            r_nxt.st  = wdgate_pkg::WD_CLOSED;
            r_nxt.cnt = 16'h0000;
          end else if (r.cnt >= wdgate_pkg::TRIG_CYCLES - 16'h0001) begin
            r_nxt.st    = wdgate_pkg::WD_FAULT;
            r_nxt.cnt   = 16'h0000;
            r_nxt.fault = 1'b0;
            ev[wdgate_pkg::EV_TIMEOUT] = 1'b1;
          end else begin
            r_nxt.cnt = r.cnt + 16'h0001;
          end
        end
        wdgate_pkg::WD_CLOSED: begin
          if (!act_nxt) begin
            r_nxt.st  = wdgate_pkg::WD_IDLE;
            r_nxt.cnt = 16'h0000;
          end else if (trig_ok) begin
            r_nxt.st    = wdgate_pkg::WD_FAULT;
            r_nxt.cnt   = 16'h0000;
            r_nxt.fault = 1'b0;
            ev[wdgate_pkg::EV_DPULSE] = 1'b1;
          end else begin
            // the trigger time keeps running from the last trigger across the window
            r_nxt.cnt = r.cnt + 16'h0001;
            if (r.cnt >= wdgate_pkg::DP_CYCLES - 16'h0001) begin
              r_nxt.st = wdgate_pkg::WD_OPEN;
            end
          end
        end
        wdgate_pkg::WD_FAULT: begin
          if (r.cnt >= wdgate_pkg::LOW_CYCLES - 16'h0001) begin
            r_nxt.fault = 1'b1;
            r_nxt.cnt   = 16'h0000;
            r_nxt.st    = act_nxt ? wdgate_pkg::WD_OPEN : wdgate_pkg::WD_IDLE;
          end else begin
            r_nxt.cnt = r.cnt + 16'h0001;
          end
        end
        default: begin
          r_nxt.st  = wdgate_pkg::WD_IDLE;
          r_nxt.cnt = 16'h0000;
        end
      endcase
    end

    r_nxt.comb = r_nxt.fault && sif.sync[wdgate_pkg::IN_UVRO];

    // apb: one wait state, the write lands on the edge that sees pready high
    acc_phase     = psel && penable && r.pready;
    r_nxt.pready  = psel && penable && !r.pready;
    r_nxt.pslverr = psel && penable && !r.pready && !mapped(paddr);
    r_nxt.prdata  = 32'h0000_0000;
    if (psel && penable && !r.pready && !pwrite) begin
      r_nxt.prdata = rd_word(paddr, r, gate_s, sense_stat);
    end
    r_nxt.irq_st = r.irq_st | ev;
    if (acc_phase && pwrite) begin
      unique case (paddr)
        wdgate_pkg::ADDR_CTRL:    r_nxt.ctrl   = pwdata[1:0];
        wdgate_pkg::ADDR_IRQ_EN:  r_nxt.irq_en = pwdata[wdgate_pkg::EV_W-1:0];
        // an event in the clearing cycle survives the clear
        wdgate_pkg::ADDR_IRQ_CLR: r_nxt.irq_st = (r.irq_st & ~pwdata[wdgate_pkg::EV_W-1:0]) | ev;
        default: ;
      endcase
    end
    r_nxt.irq = |(r_nxt.irq_st & r_nxt.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.st      <= wdgate_pkg::WD_IDLE;
      r.fault   <= 1'b1;
      r.ctrl    <= wdgate_pkg::CTRL_RST;
    end else begin
      r <= r_nxt;
    end
  end

  assign pready                 = r.pready;
  assign prdata                 = r.prdata;
  assign pslverr                = r.pslverr;
  assign fault_output           = r.fault;
  assign combined_status_output = r.comb;
  assign monitor_active         = r.active;
  assign irq                    = r.irq;

  sequence seq_fault_low;
    !fault_output [*8];
  endsequence

  sequence seq_drop_fault_high;
    $fell(monitor_active) && fault_output;
  endsequence

  AST_GATE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !sif.sync[wdgate_pkg::IN_GATE] |=> !monitor_active)
    else $error("monitoring active with gate low");

  AST_MODE_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
    (r.ctrl == wdgate_pkg::SENSE_UNUSED) |=> !monitor_active)
    else $error("monitoring active in unused mode");

  AST_VOUT_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    det_low_s |=> !monitor_active && r.st == wdgate_pkg::WD_IDLE)
    else $error("monitoring survived undervoltage");

  AST_UV_POR: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == wdgate_pkg::WD_IDLE && act_nxt) |=> r.st == wdgate_pkg::WD_POR ##1
      (r.cnt == 16'h0000))
    else $error("activation skipped power-on reset");

  AST_CLEAR_DEACT: assert property (@(posedge pclk) disable iff (!presetn)
    seq_drop_fault_high |-> r.st inside {wdgate_pkg::WD_IDLE, wdgate_pkg::WD_FAULT} &&
      (r.st == wdgate_pkg::WD_FAULT || r.cnt == 16'h0000))
    else $error("counts kept after deactivation");

  // an undervoltage trip may end the low time at once, so it aborts the check
  AST_FAULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn || det_low_s)
    $fell(fault_output) |-> seq_fault_low)
    else $error("fault output released early");

  AST_FAULT_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == wdgate_pkg::WD_FAULT && r.cnt < wdgate_pkg::LOW_CYCLES - 16'h0001 &&
      r_nxt.vout_ok) |=> !fault_output && r.st == wdgate_pkg::WD_FAULT)
    else $error("fault state left before the full low time");

  AST_TRIG_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    (sif.rise[wdgate_pkg::IN_TRIG] && (!fault_output || !monitor_active)) |=> !r.trig_acc)
    else $error("trigger accepted outside monitoring");

  AST_TRIG_CLOSE: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == wdgate_pkg::WD_OPEN && trig_ok && act_nxt) |=>
      r.st == wdgate_pkg::WD_CLOSED && r.trig_acc)
    else $error("trigger in open window not taken");

  AST_COMBINED: assert property (@(posedge pclk) disable iff (!presetn)
    combined_status_output == (fault_output && $past(sif.sync[wdgate_pkg::IN_UVRO])))
    else $error("combined output is not the AND of both outputs");

  AST_SENSE_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (gate_s && r_nxt.vout_ok && r.ctrl == wdgate_pkg::SENSE_AUTO) |=>
      monitor_active == $past(sif.sync[wdgate_pkg::IN_SENSE]))
    else $error("activation does not follow sense status");

endmodule : wd_activation_gate

// ### core/wdgate_pkg.sv
package wdgate_pkg;

  // synchronised input lanes
  localparam int          SYNC_W      = 6;
  localparam int          IN_GATE     = 0;
  localparam int          IN_SENSE    = 1;
  localparam int          IN_TRIG     = 2;
  localparam int          IN_REL_OK   = 3;
  localparam int          IN_DET_LOW  = 4;
  localparam int          IN_UVRO     = 5;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h010;

  // threshold-sense connection modes
  localparam logic [1:0]  SENSE_UNUSED = 2'h0;
  localparam logic [1:0]  SENSE_ALWAYS = 2'h1;
  localparam logic [1:0]  SENSE_AUTO   = 2'h2;
  localparam logic [1:0]  CTRL_RST     = SENSE_AUTO;

  // event bit positions
  localparam int          EV_TIMEOUT  = 0;
  localparam int          EV_DPULSE   = 1;
  localparam int          EV_TRIGGER  = 2;
  localparam int          EV_ACTCHG   = 3;
  localparam int          EV_W        = 4;

  // status register field positions
  localparam int          ST_ACTIVE   = 0;
  localparam int          ST_FAULT    = 1;
  localparam int          ST_GATE     = 2;
  localparam int          ST_SENSE    = 3;
  localparam int          ST_VOUT_OK  = 4;
  localparam int          ST_STATE    = 8;

  // window timing in clock cycles, stand-ins for the capacitor timing
  localparam logic [15:0] TRIG_CYCLES = 16'h0400;
  localparam logic [15:0] DP_CYCLES   = 16'h0100;
  localparam logic [15:0] LOW_CYCLES  = 16'h0200;

  typedef enum logic [2:0] {
    WD_IDLE,
    WD_POR,
    WD_OPEN,
    WD_CLOSED,
    WD_FAULT
  } wd_state_type;

endpackage : wdgate_pkg

// ### sim/mcu_model.sv
`timescale 1ns/1ps
module mcu_model (
  // clock
  input  wire logic pclk,
  // watchdog pins
  input  wire logic fault_output,
  output logic      trigger_input
);
  int n_faults;

  initial begin
    n_faults      = 0;
    trigger_input = 1'b0;
  end

  // high for several cycles so the synchroniser cannot miss the edge
  task automatic pulse();
    @(posedge pclk);
    trigger_input <= 1'b1;
    repeat (4) @(posedge pclk);
    trigger_input <= 1'b0;
  endtask : pulse

  // the service loop only learns of a fault from the falling output
  always @(negedge fault_output) begin
    n_faults++;
  end
endmodule : mcu_model

// ### sim/watchdog_activation_gate_bench.sv
`timescale 1ns/1ps
module watchdog_activation_gate_bench;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic        pready, pslverr, e;
  logic        watchdog_gate, current_threshold_sense, trigger_input;
  logic        release_threshold_ok, detect_threshold_low, undervoltage_reset_output;
  logic        fault_output, combined_status_output, monitor_active, irq;
  int          n_fail, checks_done, low_run, last_low;

  wd_activation_gate uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .watchdog_gate(watchdog_gate),
    .current_threshold_sense(current_threshold_sense), .trigger_input(trigger_input),
    .release_threshold_ok(release_threshold_ok), .detect_threshold_low(detect_threshold_low),
    .undervoltage_reset_output(undervoltage_reset_output), .fault_output(fault_output),
    .combined_status_output(combined_status_output), .monitor_active(monitor_active),
    .irq(irq));

  mcu_model mcu (.pclk(pclk), .fault_output(fault_output), .trigger_input(trigger_input));

  always #20 pclk = ~pclk;

  // length of the most recent fault-low stretch, in cycles
  always @(posedge pclk) begin
    if (fault_output === 1'b0) begin
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      last_low <= low_run;
      low_run  <= 0;
    end
  end

  task automatic close_out();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail++;
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic g, input logic s, input logic r, input logic dl);
    @(posedge pclk);
    watchdog_gate           <= g;
    current_threshold_sense <= s;
    release_threshold_ok    <= r;
    detect_threshold_low    <= dl;
    repeat (6) @(posedge pclk);
  endtask : pins

  task automatic t_reset();
    chk(fault_output, 1'b1);
    apb(1'b0, wdgate_pkg::ADDR_CTRL, 32'h0);
    chk(d, wdgate_pkg::CTRL_RST);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(e, 1'b1);
  endtask : t_reset

  task automatic t_table();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, wdgate_pkg::ADDR_CTRL, 32'(m));
      for (int c = 0; c < 4; c++) begin
        pins(c[1], c[0], 1'b1, 1'b0);
        chk(monitor_active, c[1] & (m == 1 || (m >= 2 && c[0])));
      end
    end
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk(monitor_active, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    chk(monitor_active, 1'b1);
  endtask : t_table

  task automatic t_vout();
    pins(1'b1, 1'b1, 1'b0, 1'b1);
    chk(monitor_active, 1'b0);
    apb(1'b0, wdgate_pkg::ADDR_STATUS, 32'h0);
    chk(d[10:8], wdgate_pkg::WD_IDLE);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk(monitor_active, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    chk(monitor_active, 1'b1);
    apb(1'b0, wdgate_pkg::ADDR_STATUS, 32'h0);
    chk(d[10:8], wdgate_pkg::WD_OPEN);
  endtask : t_vout

  task automatic t_trig();
    apb(1'b1, wdgate_pkg::ADDR_IRQ_EN, 32'h2);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    apb(1'b1, wdgate_pkg::ADDR_IRQ_CLR, 32'hF);
    mcu.pulse();
    repeat (6) @(posedge pclk);
    apb(1'b0, wdgate_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(d[wdgate_pkg::EV_TRIGGER], 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    mcu.pulse();
    repeat (6) @(posedge pclk);
    apb(1'b0, wdgate_pkg::ADDR_STATUS, 32'h0);
    chk(d[10:8], wdgate_pkg::WD_CLOSED);
    chk(irq, 1'b0);
    mcu.pulse();
    repeat (6) @(posedge pclk);
    chk(fault_output, 1'b0);
    chk(combined_status_output, 1'b0);
    chk(mcu.n_faults, 1);
    chk(irq, 1'b1);
    apb(1'b1, wdgate_pkg::ADDR_IRQ_EN, 32'h0);
    // the write lands on the edge that ends the transfer; irq falls on that same edge and is sampled one edge later
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, wdgate_pkg::ADDR_IRQ_CLR, 32'hF);
    // trigger while faulted must not be taken
    mcu.pulse();
    repeat (6) @(posedge pclk);
    apb(1'b0, wdgate_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(d[wdgate_pkg::EV_TRIGGER], 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    chk(monitor_active, 1'b0);
    chk(fault_output, 1'b0);
    repeat (600) @(posedge pclk);
    chk(fault_output, 1'b1);
    chk(last_low, 32'(wdgate_pkg::LOW_CYCLES));
    @(posedge pclk);
    undervoltage_reset_output <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(combined_status_output, 1'b0);
    undervoltage_reset_output <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(combined_status_output, 1'b1);
  endtask : t_trig

  task automatic t_timeout();
    int k;
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (800) @(posedge pclk);
    // a short drop of the gate must restart the trigger time from zero
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (900) @(posedge pclk);
    chk(fault_output, 1'b1);
    k = 0;
    while (fault_output !== 1'b0 && k < 300) begin
      @(posedge pclk);
      k++;
    end
    chk(fault_output, 1'b0);
    chk(mcu.n_faults, 2);
    apb(1'b0, wdgate_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(d[wdgate_pkg::EV_TIMEOUT], 1'b1);
  endtask : t_timeout

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    watchdog_gate = 1'b0;
    current_threshold_sense = 1'b0;
    release_threshold_ok = 1'b0;
    detect_threshold_low = 1'b0;
    undervoltage_reset_output = 1'b1;
    n_fail = 0;
    checks_done = 0;
    low_run = 0;
    last_low = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_table();
    t_vout();
    t_trig();
    t_timeout();
    close_out();
  end

  // the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
endmodule : watchdog_activation_gate_bench
